/* File: rtl/host_run_reset_map.svh */
// Register offsets, field positions, reset values and timing counts of the run/reset control block
`ifndef HOST_RUN_RESET_MAP_SVH
`define HOST_RUN_RESET_MAP_SVH

`define CMD_OFFSET 4'h0
`define STAT_OFFSET 4'h4
`define RUN_STOP_BIT 0
`define SOFT_RESET_BIT 1
`define FLS_LSB 2
`define FLS_MSB 3
`define HALTED_BIT 12
`define FLS_1024 2'h0
`define FLS_512 2'h1
`define FLS_256 2'h2
`define FLS_RSVD 2'h3
`define RESET_CYCLES_DEFAULT 16
`define RESET_CYCLES_WIDTH 8

`endif

/* File: rtl/host_run_reset_pkg.sv */
// Types of the run/reset control block
package host_run_reset_pkg;

    typedef enum logic [1:0] {
        ST_HALTED,
        ST_RUNNING,
        ST_STOPPING,
        ST_RESETTING
    } ctrl_state_t;

endpackage

/* File: rtl/reset_sequencer.sv */
// Software reset duration counter
`timescale 1ns/10ps
`default_nettype none

module reset_sequencer #(
    parameter int CYCLES = 16,
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic busy_reg;
    logic busy_next;
    logic done_reg;
    wire last_w = (count_reg == WIDTH'(CYCLES - 1));

    initial begin
        if (CYCLES < 1 || CYCLES >= (1 << WIDTH)) begin
            $error("reset_sequencer: CYCLES out of range");
        end
    end

    assign busy_next = busy_reg ? !last_w : start_i;
    assign count_next = (busy_reg && !last_w) ? count_reg + WIDTH'(1) : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg <= 1'b0;
            count_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next;
            count_reg <= count_next;
            done_reg <= busy_reg && last_w;
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;

endmodule // reset_sequencer

`default_nettype wire

/* File: rtl/host_run_reset_control.sv */
// Run/stop, software reset and frame list size control with Avalon-MM slave
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "host_run_reset_map.svh"

// What this block does
// (R1) Soft reset returns all pipelines, timers, counters, state machines to initial values.
// (R2) Soft reset affects root hub registers like a chip hardware reset.
// (R3) Setting soft reset aborts any USB transaction in progress at once.
// (R4) Soft reset drives no bus reset signalling on downstream ports.
// (R5) Soft reset leaves bus configuration space registers unchanged.
// (R6) Soft reset restores every operational register, port registers and port machines.
// (R7) Soft reset hands ownership of every port back to companion controllers.
// (R8) Controller clears the reset bit itself when reset finishes; set until then.
// (R9) Writing 0 to the reset bit does not shorten or end the reset.
// (R10) Software fully re-initialises the controller after a soft reset.
// (R11) Software checks halted flag before reset; resetting a running controller is undefined.
// (R12) Run/stop bit: 1 requests running, 0 requests stopping.
// (R13) While run/stop is set the schedule keeps executing.
// (R14) On run/stop clear, finish pipeline transactions, then halt.
// (R15) Halted flag asserts only after pending transaction done and stopped state entered.
// (R16) Frame list size 10b selects 256 entries, 1024 bytes; 11b reserved.
// (R17) Frame list size 00b selects 1024 entries; 01b selects 512 entries.
// (R18) After soft reset, run/stop reads 0 and halted flag reads 1.
module host_run_reset_control #(
    parameter int RESET_CYCLES = `RESET_CYCLES_DEFAULT,
    parameter int NUM_PORTS = 2
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic PIPE_IDLE_I,
    output logic SCHEDULE_RUN_O,
    output logic TRANSACTION_ABORT_O,
    output logic OPER_REGS_RESET_O,
    output logic [NUM_PORTS-1:0] PORT_TO_COMPANION_O,
    output logic [10:0] FRAME_LIST_ENTRIES_O,
    output logic [12:0] FRAME_LIST_BYTES_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter check

    initial begin
        if (NUM_PORTS < 1 || NUM_PORTS > 15) begin
            $error("host_run_reset_control: NUM_PORTS out of range");
        end
        if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << `RESET_CYCLES_WIDTH)) begin
            $error("host_run_reset_control: RESET_CYCLES out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State and registers

    host_run_reset_pkg::ctrl_state_t state_reg;
    host_run_reset_pkg::ctrl_state_t state_next;
    logic run_stop_control_reg;
    logic run_stop_control_next;
    logic [1:0] fls_reg;
    logic [1:0] fls_next;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic pipe_idle_meta_reg;
    logic pipe_idle_reg;
    logic seq_busy;
    logic seq_done;
    logic [NUM_PORTS-1:0] companion_reg;

    logic [10:0] entries_reg;
    logic [12:0] bytes_reg;
    logic [31:0] cmd_view;
    logic [31:0] stat_view;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire req_w = AVS_READ_I || AVS_WRITE_I;
    wire take_w = req_w && ack_reg;
    wire cmd_sel_w = (AVS_ADDRESS_I == `CMD_OFFSET);
    wire stat_sel_w = (AVS_ADDRESS_I == `STAT_OFFSET);
    wire cmd_wr_w = take_w && AVS_WRITE_I && cmd_sel_w && AVS_BYTEENABLE_I[0];
    wire halted_flag = (state_reg == host_run_reset_pkg::ST_HALTED);
    wire resetting_w = (state_reg == host_run_reset_pkg::ST_RESETTING);
    wire soft_reset_req_w = cmd_wr_w && AVS_WRITEDATA_I[`SOFT_RESET_BIT] && !resetting_w;
    wire controller_soft_reset = resetting_w;

    // Frame list size may only change while the schedule is stopped
    wire [1:0] fls_field_w = AVS_WRITEDATA_I[`FLS_MSB:`FLS_LSB];
    wire run_bit_w = AVS_WRITEDATA_I[`RUN_STOP_BIT];
    wire fls_legal_w = (fls_field_w != `FLS_RSVD);
    wire fls_wr_ok_w = !run_stop_control_reg && halted_flag && fls_legal_w;
    wire accept_w = req_w && !ack_reg;

    // One wait cycle per access, read data from a register
    assign AVS_WAITREQUEST_O = req_w && !ack_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Pipeline idle synchroniser

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            pipe_idle_meta_reg <= 1'b1;
        end else begin
            pipe_idle_meta_reg <= PIPE_IDLE_I;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            pipe_idle_reg <= 1'b1;
        end else begin
            pipe_idle_reg <= pipe_idle_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset duration

    reset_sequencer #(
        .CYCLES(RESET_CYCLES),
        .WIDTH(`RESET_CYCLES_WIDTH)
    ) u_reset_sequencer (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .start_i(soft_reset_req_w),
        .busy_o(seq_busy),
        .done_o(seq_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Control state machine

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            host_run_reset_pkg::ST_HALTED: begin
                if (run_stop_control_reg) begin
                    state_next = host_run_reset_pkg::ST_RUNNING; // R12
                end
            end

            host_run_reset_pkg::ST_RUNNING: begin
                if (!run_stop_control_reg) begin
                    state_next = host_run_reset_pkg::ST_STOPPING; // R14
                end
            end

            host_run_reset_pkg::ST_STOPPING: begin
                if (pipe_idle_reg) begin
                    state_next = host_run_reset_pkg::ST_HALTED; // R15
                end
            end

            host_run_reset_pkg::ST_RESETTING: begin
                if (seq_done) begin
                    state_next = host_run_reset_pkg::ST_HALTED; // R8 R18
                end
            end
        endcase

        // Soft reset wins over every state except ST_RESETTING, where a new request is ignored
        if (soft_reset_req_w) begin
            state_next = host_run_reset_pkg::ST_RESETTING; // R1 R3
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command fields

    always_comb begin
        run_stop_control_next = run_stop_control_reg;
        fls_next = fls_reg;
        if (resetting_w || soft_reset_req_w) begin
            run_stop_control_next = 1'b0; // R6 R18
            fls_next = `FLS_1024; // R6
        end else if (cmd_wr_w) begin
            run_stop_control_next = run_bit_w; // R12
            if (fls_wr_ok_w) begin
                fls_next = fls_field_w; // R16
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        cmd_view = 32'h0;
        cmd_view[`RUN_STOP_BIT] = run_stop_control_reg;
        cmd_view[`SOFT_RESET_BIT] = controller_soft_reset; // R8 R9
        cmd_view[`FLS_MSB:`FLS_LSB] = fls_reg;
    end

    always_comb begin
        stat_view = 32'h0;
        stat_view[`HALTED_BIT] = halted_flag; // R15
    end

    assign rdata_next = cmd_sel_w ? cmd_view : (stat_sel_w ? stat_view : 32'h0);

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            rdata_reg <= 32'h0;
        end else if (accept_w) begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= accept_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            state_reg <= host_run_reset_pkg::ST_HALTED;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            run_stop_control_reg <= 1'b0;
        end else begin
            run_stop_control_reg <= run_stop_control_next;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            fls_reg <= `FLS_1024;
        end else begin
            fls_reg <= fls_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port ownership, one flip-flop per port

    // Ownership only ever returns to the companions here
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            always_ff @(posedge CLOCK_I) begin
                if (RESET_I || soft_reset_req_w) begin
                    companion_reg[p] <= 1'b1; // R7
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // R4 R5: no bus reset line and no configuration state exist here
    wire running_w = (state_reg == host_run_reset_pkg::ST_RUNNING);
    wire stopping_w = (state_reg == host_run_reset_pkg::ST_STOPPING);
    assign SCHEDULE_RUN_O = running_w || stopping_w; // R13
    assign TRANSACTION_ABORT_O = soft_reset_req_w || resetting_w; // R3
    assign OPER_REGS_RESET_O = resetting_w || seq_busy; // R2 R6
    assign PORT_TO_COMPANION_O = companion_reg; // R7
    assign AVS_READDATA_O = rdata_reg;

    assign FRAME_LIST_ENTRIES_O = entries_reg;
    assign FRAME_LIST_BYTES_O = bytes_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame list size decode, registered

    wire fls_is_512_w = (fls_reg == `FLS_512);
    wire fls_is_256_w = (fls_reg == `FLS_256);
    wire [10:0] entries_next_w = fls_is_512_w ? 11'h200 : (fls_is_256_w ? 11'h100 : 11'h400); // R16 R17

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            entries_reg <= 11'h400;
            bytes_reg <= 13'h1000;
        end else begin
            entries_reg <= entries_next_w; // R16 R17
            bytes_reg <= {entries_next_w, 2'h0};
        end
    end

endmodule // host_run_reset_control

`default_nettype wire

/* File: dv/host_run_reset_control_properties.sv */
// Checker for the run/reset control block
`timescale 1ns/10ps
`default_nettype none
module host_run_reset_checker #(
    parameter int RESET_CYCLES = 16,
    parameter int NUM_PORTS = 2
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic SCHEDULE_RUN_O,
    input wire logic TRANSACTION_ABORT_O,
    input wire logic OPER_REGS_RESET_O,
    input wire logic [NUM_PORTS-1:0] PORT_TO_COMPANION_O,
    input wire logic [10:0] FRAME_LIST_ENTRIES_O,
    input wire logic [12:0] FRAME_LIST_BYTES_O
);
    logic [8:0] rst_cnt_reg;
    wire logic [8:0] rst_cnt_next = OPER_REGS_RESET_O ? rst_cnt_reg + 9'h1 : 9'h0;
    wire logic rst_take = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'h0
        && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[1];
    always_ff @(posedge CLOCK_I) begin
        rst_cnt_reg <= RESET_I ? 9'h0 : rst_cnt_next;
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    ////////////////////////////////////////////////////////////////////////
    property p_wait; $rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O; endproperty
    a_wait: assert property (p_wait) else $error("waitrequest timing wrong");
    property p_abort; rst_take |-> TRANSACTION_ABORT_O; endproperty
    a_abort: assert property (p_abort) else $error("no abort on reset write");
    property p_start; rst_take |-> ##[1:2] OPER_REGS_RESET_O; endproperty
    a_start: assert property (p_start) else $error("soft reset did not start");
    property p_hold; OPER_REGS_RESET_O |-> TRANSACTION_ABORT_O && !SCHEDULE_RUN_O; endproperty
    a_hold: assert property (p_hold) else $error("activity during soft reset");
    property p_companion; OPER_REGS_RESET_O |-> &PORT_TO_COMPANION_O; endproperty
    a_companion: assert property (p_companion) else $error("ports not with companion");
    property p_len; $fell(OPER_REGS_RESET_O) |-> rst_cnt_reg >= RESET_CYCLES - 1; endproperty
    a_len: assert property (p_len) else $error("soft reset too short");
    property p_bound; OPER_REGS_RESET_O |-> rst_cnt_reg <= RESET_CYCLES + 2; endproperty
    a_bound: assert property (p_bound) else $error("soft reset never ends");
    property p_after; $fell(OPER_REGS_RESET_O) |-> !SCHEDULE_RUN_O && FRAME_LIST_ENTRIES_O == 11'h400; endproperty
    a_after: assert property (p_after) else $error("state wrong after soft reset");
    property p_bytes; FRAME_LIST_BYTES_O == {FRAME_LIST_ENTRIES_O, 2'h0}; endproperty
    a_bytes: assert property (p_bytes) else $error("frame list bytes wrong");
    property p_entries; FRAME_LIST_ENTRIES_O inside {11'h400, 11'h200, 11'h100}; endproperty
    a_entries: assert property (p_entries) else $error("frame list size illegal");
    c_reset: cover property (rst_take);
    c_run: cover property ($rose(SCHEDULE_RUN_O));
    c_halt: cover property ($fell(SCHEDULE_RUN_O));
endmodule // host_run_reset_checker
bind host_run_reset_control host_run_reset_checker #(.RESET_CYCLES(RESET_CYCLES), .NUM_PORTS(NUM_PORTS)) chk (
    .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .SCHEDULE_RUN_O(SCHEDULE_RUN_O),
    .TRANSACTION_ABORT_O(TRANSACTION_ABORT_O), .OPER_REGS_RESET_O(OPER_REGS_RESET_O),
    .PORT_TO_COMPANION_O(PORT_TO_COMPANION_O), .FRAME_LIST_ENTRIES_O(FRAME_LIST_ENTRIES_O),
    .FRAME_LIST_BYTES_O(FRAME_LIST_BYTES_O));
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking testbench of the run/reset control block
`timescale 1ns/10ps
`default_nettype none
`include "host_run_reset_map.svh"
module testbench;
    localparam int RC = 20;
    logic clk, rst, rd, wr, pipe_idle, wait_o, run_o, abort_o, oreg_o;
    logic [3:0] addr, be;
    logic [31:0] wdata, rdata, q, rnd;
    logic [1:0] comp_o;
    logic [10:0] ent_o;
    logic [12:0] byt_o;
    int fail_count, checks_done, seed, cyc, t0, n, v, fls_m;
    host_run_reset_control #(.RESET_CYCLES(RC), .NUM_PORTS(2)) dut (.CLOCK_I(clk), .RESET_I(rst),
        .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_o), .PIPE_IDLE_I(pipe_idle),
        .SCHEDULE_RUN_O(run_o), .TRANSACTION_ABORT_O(abort_o), .OPER_REGS_RESET_O(oreg_o),
        .PORT_TO_COMPANION_O(comp_o), .FRAME_LIST_ENTRIES_O(ent_o), .FRAME_LIST_BYTES_O(byt_o));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        addr <= a; rd <= !w; wr <= w; wdata <= d;
        @(posedge clk);
        while (wait_o !== 1'b0 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) begin
            fail_count++;
            test_done();
        end
        q = rdata;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    task automatic wr_cmd(input logic [3:0] ctl);
        rnd = $random(seed);
        bus(1'b1, `CMD_OFFSET, {rnd[31:4], ctl});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hf584; cyc = 0; fail_count = 0; checks_done = 0;
        rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 4'h0; wdata = 32'h0; be = 4'hf; pipe_idle = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, `CMD_OFFSET, 32'h0); check(q[3:0], 32'h0);
        bus(1'b0, `STAT_OFFSET, 32'h0); check(q[`HALTED_BIT], 32'h1);
        check(comp_o, 32'h3);
        bus(1'b0, 4'h8, 32'h0); check(q, 32'h0);
        fls_m = 0;
        for (v = 0; v < 4; v++) begin
            wr_cmd({v[1:0], 2'h0});
            if (v != 3) fls_m = v;
            bus(1'b0, `CMD_OFFSET, 32'h0); check(q[3:2], fls_m);
            check(ent_o, 32'h400 >> fls_m);
            check(byt_o, 32'h1000 >> fls_m);
        end
        pipe_idle <= 1'b0;
        be <= 4'he;
        wr_cmd({2'h2, 2'h1}); @(negedge clk); check(run_o, 32'h0);
        be <= 4'hf;
        wr_cmd({2'h2, 2'h1}); repeat (3) @(posedge clk); @(negedge clk); check(run_o, 32'h1);
        bus(1'b0, `STAT_OFFSET, 32'h0); check(q[`HALTED_BIT], 32'h0);
        wr_cmd({2'h2, 2'h0}); repeat (8) @(posedge clk); @(negedge clk); check(run_o, 32'h1);
        bus(1'b0, `STAT_OFFSET, 32'h0); check(q[`HALTED_BIT], 32'h0);
        pipe_idle <= 1'b1;
        for (n = 0; n < 20 && q[`HALTED_BIT] !== 1'b1; n++) bus(1'b0, `STAT_OFFSET, 32'h0);
        check(q[`HALTED_BIT], 32'h1);
        @(negedge clk); check(run_o, 32'h0);
        wr_cmd({2'h1, 2'h0});
        // Halted was seen above, so the soft reset is legal here
        wr_cmd({2'h1, 2'h2}); t0 = cyc;
        @(negedge clk); check(abort_o, 32'h1);
        check(oreg_o, 32'h1);
        check(comp_o, 32'h3);
        check(run_o, 32'h0);
        wr_cmd(4'h0);
        bus(1'b0, `CMD_OFFSET, 32'h0); check(q[1], 32'h1);
        for (n = 0; n < 40 && q[1] !== 1'b0; n++) bus(1'b0, `CMD_OFFSET, 32'h0);
        check(cyc - t0 >= RC, 32'h1);
        check(q[3:0], 32'h0);
        bus(1'b0, `STAT_OFFSET, 32'h0); check(q[`HALTED_BIT], 32'h1);
        @(negedge clk); check(ent_o, 32'h400);
        check(abort_o, 32'h0);
        check(oreg_o, 32'h0);
        wr_cmd({2'h1, 2'h1});
        rst <= 1'b1; repeat (2) @(posedge clk); rst <= 1'b0;
        @(negedge clk); check(run_o, 32'h0);
        check(ent_o, 32'h400);
        bus(1'b0, `CMD_OFFSET, 32'h0); check(q[3:0], 32'h0);
        bus(1'b0, `STAT_OFFSET, 32'h0); check(q[`HALTED_BIT], 32'h1);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done();
    end
endmodule // testbench
`default_nettype wire
